// ### logic/ipsm_input_pin_select_mux.sv
// AHB-Lite input pin select crossbar with lock, shadow check and assertions.
//
// Decided for this implementation: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/100ps
`include "ipsm_params.svh"

module ipsm_input_pin_select_mux #(
  parameter int NUM_PINS = `IPSM_DEF_PINS  // Remappable pins, at most 64.
) (
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic      [31:0]              hrdata,
  output logic                          hreadyout,
  output logic                          hresp,
  input  wire logic                     remap_lock,
  input  wire logic [NUM_PINS-1:0]      remap_pin,
  output ipsm_pkg::ipsm_periph_type     periph_in,
  output logic                          cfg_mismatch_rst
);

  ipsm_pkg::ipsm_state_type q;  // Registered state.
  ipsm_pkg::ipsm_state_type d;  // Next state.

  // Maps a byte offset to a register slot; slot 7 is register 8.
  function automatic logic [3:0] slot_of(input logic [7:0] a);
    logic [3:0] s;
    s = 4'hF;
    if (a == `IPSM_OFS_SEL0) begin
      s = 4'h0;
    end else if (a == `IPSM_OFS_SEL1) begin
      s = 4'h1;
    end else if (a == `IPSM_OFS_SEL2) begin
      s = 4'h2;
    end else if (a == `IPSM_OFS_SEL3) begin
      s = 4'h3;
    end else if (a == `IPSM_OFS_SEL5) begin
      s = 4'h4;
    end else if (a == `IPSM_OFS_SEL6) begin
      s = 4'h5;
    end else if (a == `IPSM_OFS_SEL7) begin
      s = 4'h6;
    end else if (a == `IPSM_OFS_SEL8) begin
      s = 4'h7;
    end
    return s;
  endfunction

  logic [3:0]  wslot;     // Slot addressed by the open write.
  logic [3:0]  rslot;     // Slot addressed by a read address phase.
  logic        take;      // A transfer address phase is accepted.
  logic [14:0] pick;      // Pin level that each field selects.
  logic        can_wr;    // The open write may change the selects.

  // Next-state logic: pins, bus slave, select writes, routing and checking.
  always_comb begin
    d = q;
    // Two stages before any logic looks at the pins.
    d.sync1 = 64'(remap_pin);
    d.sync2 = q.sync1;

    // A locked write is swallowed; the bus still sees OKAY.
    can_wr = q.wr_pend && !remap_lock && hready;
    wslot = slot_of(q.wr_addr);
    if (can_wr && (wslot != 4'hF)) begin
      // Low field of the slot, bits 5-0; bits 7-6 and 15-14 are dropped.
      d.sel[2*wslot] = hwdata[`IPSM_LO_POS +: `IPSM_FLD_W];
      d.shadow[2*wslot] = hwdata[`IPSM_LO_POS +: `IPSM_FLD_W];
      // High field, bits 13-8, exists in every slot but the last.
      if (wslot != 4'h7) begin
        d.sel[2*wslot+1] = hwdata[`IPSM_HI_POS +: `IPSM_FLD_W];
        d.shadow[2*wslot+1] = hwdata[`IPSM_HI_POS +: `IPSM_FLD_W];
      end
    end

    // Address phase; only whole-word transfers are acted on.
    take = hsel && htrans[1] && hready && (hsize == `IPSM_HSIZE_WORD);
    if (hready) begin
      d.wr_pend = take && hwrite;
      d.wr_addr = haddr[`IPSM_AW-1:0];
    end

    // Read data comes from the next selects, so a read right after a write sees it.
    rslot = slot_of(haddr[`IPSM_AW-1:0]);
    if (hready) begin
      d.rdata = 32'h0000_0000;
      if (take && !hwrite) begin
        if (rslot != 4'hF) begin
          // Fields sit in bits 5-0 and 13-8; every other bit reads zero.
          d.rdata[`IPSM_LO_POS +: `IPSM_FLD_W] = d.sel[2*rslot];
          if (rslot != 4'h7) begin
            d.rdata[`IPSM_HI_POS +: `IPSM_FLD_W] = d.sel[2*rslot+1];
          end
        end else if (haddr[`IPSM_AW-1:0] == `IPSM_OFS_STAT) begin
          // Status shows the lock level and the sticky mismatch.
          d.rdata[`IPSM_STAT_LOCK] = remap_lock;
          d.rdata[`IPSM_STAT_MISM] = q.mism;
        end
      end
    end

    // Route each field; a number past the last pin gives low, all ones too while NUM_PINS is below 64.
    for (int f = 0; f < `IPSM_FIELDS; f++) begin
      pick[f] = (int'(q.sel[f]) < NUM_PINS) ? q.sync2[q.sel[f]] : 1'b0;
    end
    d.periph = ipsm_pkg::ipsm_periph_type'(pick);

    // Any difference between live and shadow copies requests a reset.
    d.mism = q.mism || (q.sel != q.shadow);
  end

  // State register; select fields and shadows come out of reset as all ones.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.sel <= {`IPSM_FIELDS{`IPSM_SEL_RST}};
      q.shadow <= {`IPSM_FIELDS{`IPSM_SEL_RST}};
    end else begin
      q <= d;
    end
  end

  // Outputs: zero wait states and always OKAY.
  assign hrdata = q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign periph_in = q.periph;
  assign cfg_mismatch_rst = q.mism;

  // Helpers read only by the checks below.
  logic [14:0] pv;     // Peripheral outputs as a vector.
  logic        pick1;  // Pin that field 1 currently selects.
  logic [5:0]  sel3;   // Field 3, high half of register 1.
  assign pv = periph_in;
  assign pick1 = (int'(q.sel[1]) < NUM_PINS) ? q.sync2[q.sel[1]] : 1'b0;
  assign sel3 = q.sel[3];

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Read address phases for register 1 with no write in flight, and for register 8.
  sequence s_rd1;
    take && !hwrite && (haddr[7:0] == `IPSM_OFS_SEL1) && !q.wr_pend;
  endsequence
  sequence s_rd8;
    take && !hwrite && (haddr[7:0] == `IPSM_OFS_SEL8);
  endsequence
  // Unlocked write data phase to register 0.
  sequence s_wr0;
    q.wr_pend && !remap_lock && hready && (q.wr_addr == `IPSM_OFS_SEL0);
  endsequence

  property p_lock_hold;
    q.wr_pend && remap_lock |=> $stable(q.sel) || $past(q.sel != q.shadow);
  endproperty
  a_lock_hold: assert property (p_lock_hold)
    else $error("select changed while locked");

  property p_okay;
    hreadyout && !hresp;
  endproperty
  a_okay: assert property (p_okay)
    else $error("slave answer not ready OKAY");

  property p_no_pin_low;
    (int'(q.sel[0]) >= NUM_PINS) |=> !pv[0];
  endproperty
  a_no_pin_low: assert property (p_no_pin_low)
    else $error("unrouted input not low");

  property p_route;
    1'b1 |=> pv[1] == $past(pick1);
  endproperty
  a_route: assert property (p_route)
    else $error("irq one input not the selected pin");

  property p_wr0;
    s_wr0 |=> (q.sel[0] == $past(hwdata[5:0])) && (q.sel[1] == $past(hwdata[13:8]));
  endproperty
  a_wr0: assert property (p_wr0)
    else $error("register 0 write not stored");

  property p_rd8;
    s_rd8 |=> hrdata[31:6] == 26'h0000000;
  endproperty
  a_rd8: assert property (p_rd8)
    else $error("register 8 upper bits not zero");

  property p_rd1;
    s_rd1 |=> (hrdata[13:8] == $past(sel3)) && (hrdata[15:14] == 2'h0);
  endproperty
  a_rd1: assert property (p_rd1)
    else $error("register 1 read wrong");

  property p_mism;
    (q.sel != q.shadow) |=> cfg_mismatch_rst ##1 cfg_mismatch_rst;
  endproperty
  a_mism: assert property (p_mism)
    else $error("mismatch reset not raised");

  // Further checks on the register slots, the lock and the last field.
  // They look at outputs and at the select, shadow and synchroniser state; bus and lock give the context.
  // Each one is reached by the ordinary register traffic of a test.

  // Unlocked write data phases to registers 3 and 8.
  sequence s_wr3;
    q.wr_pend && !remap_lock && hready && (q.wr_addr == `IPSM_OFS_SEL3);
  endsequence
  sequence s_wr8;
    q.wr_pend && !remap_lock && hready && (q.wr_addr == `IPSM_OFS_SEL8);
  endsequence
  // A locked write data phase, whatever its address.
  sequence s_wr_locked;
    q.wr_pend && remap_lock;
  endsequence
  // Any word read address phase, and one aimed at the status word.
  sequence s_rd_any;
    take && !hwrite;
  endsequence
  sequence s_rd_stat;
    take && !hwrite && (haddr[7:0] == `IPSM_OFS_STAT);
  endsequence

  // Bits 31-14 and 7-6 never carry data on any read.
  property p_unimpl_zero;
    s_rd_any |=> (hrdata[31:14] == 18'h00000) && (hrdata[7:6] == 2'h0);
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero)
    else $error("unimplemented read bits not zero");

  // A register 3 write lands in fields 6 and 7, the timer clock selects.
  property p_wr3;
    s_wr3 |=> (q.sel[6] == $past(hwdata[5:0])) && (q.sel[7] == $past(hwdata[13:8]));
  endproperty
  a_wr3: assert property (p_wr3)
    else $error("register 3 write not stored");

  // A register 8 write lands in field 14 only; field 13 keeps its value.
  property p_wr8;
    s_wr8 |=> (q.sel[14] == $past(hwdata[5:0])) && $stable(q.sel[13]);
  endproperty
  a_wr8: assert property (p_wr8)
    else $error("register 8 write wrong");

  // A locked data phase leaves every live field and every shadow alone.
  property p_locked_keep;
    s_wr_locked |=> $stable(q.sel) && $stable(q.shadow);
  endproperty
  a_locked_keep: assert property (p_locked_keep)
    else $error("locked write changed a select");

  // The status word shows the lock level seen in its address phase.
  property p_stat_lock;
    s_rd_stat |=> hrdata[`IPSM_STAT_LOCK] == $past(remap_lock);
  endproperty
  a_stat_lock: assert property (p_stat_lock)
    else $error("status lock bit wrong");

  // While NUM_PINS is below 64, an all-ones select holds its peripheral input low, here the last field.
  property p_all_ones_low;
    (q.sel[14] == `IPSM_SEL_RST) |=> !pv[14];
  endproperty
  a_all_ones_low: assert property (p_all_ones_low)
    else $error("all-ones select not low");

  // Field 14 forwards the synchronised level of the pin that it names.
  property p_route14;
    (int'(q.sel[14]) < NUM_PINS) |=> pv[14] == $past(q.sync2[q.sel[14]]);
  endproperty
  a_route14: assert property (p_route14)
    else $error("capture three input not the selected pin");

  // Read data stands only in a read data phase and is zero otherwise.
  property p_rd_idle;
    (hready && !(take && !hwrite)) |=> (hrdata == 32'h0000_0000);
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside a read");

endmodule

// ### logic/ipsm_params.svh
// Offsets, field positions, reset values and sizes of the input pin select block.
`ifndef IPSM_PARAMS_SVH
`define IPSM_PARAMS_SVH

// Byte offsets of the select registers: four times the register number.
`define IPSM_OFS_SEL0   8'h00
`define IPSM_OFS_SEL1   8'h04
`define IPSM_OFS_SEL2   8'h08
`define IPSM_OFS_SEL3   8'h0C
`define IPSM_OFS_SEL5   8'h14
`define IPSM_OFS_SEL6   8'h18
`define IPSM_OFS_SEL7   8'h1C
`define IPSM_OFS_SEL8   8'h20
// Byte offset of the status register.
`define IPSM_OFS_STAT   8'h40

// Width of one select field and its low and high positions in a register.
`define IPSM_FLD_W      6
`define IPSM_LO_POS     0
`define IPSM_HI_POS     8
// Reset value of every select field: all ones, which routes no pin while NUM_PINS is below 64.
`define IPSM_SEL_RST    6'h3F
// Status bit positions.
`define IPSM_STAT_LOCK  0
`define IPSM_STAT_MISM  1

// Register slots, select fields and the widest pin set the block can hold.
`define IPSM_SLOTS      8
`define IPSM_FIELDS     15
`define IPSM_MAX_PINS   64
// Documented count of remappable pin numbers (0 to 32).
`define IPSM_DEF_PINS   33
// Bits of haddr that take part in the decode.
`define IPSM_AW         8
// AHB encodings used by the slave.
`define IPSM_HSIZE_WORD 3'h2

`endif

// ### logic/ipsm_pkg.sv
// Types of the input pin select block.
package ipsm_pkg;
  // Peripheral inputs fed by the crossbar, field 0 in the lowest bit.
  typedef struct packed {
    logic capture_three;
    logic capture_two;
    logic capture_one;
    logic capture_mode_four;
    logic capture_mode_three;
    logic capture_mode_two;
    logic capture_mode_one;
    logic timer_three_clk;
    logic timer_two_clk;
    logic cmp_trigger_two;
    logic ext_irq_four;
    logic ext_irq_three;
    logic ext_irq_two;
    logic ext_irq_one;
    logic cmp_trigger_one;
  } ipsm_periph_type;

  // Whole state of the block, registered as one word.
  typedef struct packed {
    logic [14:0][5:0] sel;     // Live select fields.
    logic [14:0][5:0] shadow;  // Shadow copy of the select fields.
    logic [63:0]      sync1;   // First synchroniser stage of the pins.
    logic [63:0]      sync2;   // Second synchroniser stage of the pins.
    logic             wr_pend; // A write data phase is open.
    logic [7:0]       wr_addr; // Address of that write.
    logic [31:0]      rdata;   // Read data of the open data phase.
    ipsm_periph_type  periph;  // Registered peripheral inputs.
    logic             mism;    // Sticky configuration mismatch.
  } ipsm_state_type;
endpackage

// ### verification/test_input_pin_select_mux.sv
// Self-checking bench of the input pin select crossbar on its AHB-Lite port.
`timescale 1ns/100ps
`include "ipsm_params.svh"

module test_input_pin_select_mux;
  // One expected result waiting for the monitor.
  typedef struct {
    string       name;
    logic [31:0] exp;
  } ipsm_note_type;
  localparam int NP = `IPSM_DEF_PINS;        // Pins given to the design.
  logic                      hclk = 1'b0;    // Bus clock.
  logic                      hresetn = 1'b0; // Active-low reset.
  logic                      hsel = 1'b0;
  logic [31:0]               haddr = 32'h0;
  logic [1:0]                htrans = 2'h0;
  logic                      hwrite = 1'b0;
  logic [2:0]                hsize = `IPSM_HSIZE_WORD;
  logic [31:0]               hwdata = 32'h0;
  logic [31:0]               hrdata;
  logic                      hreadyout;
  logic                      hresp;
  logic                      remap_lock = 1'b0;
  logic [NP-1:0]             remap_pin = '0;
  ipsm_pkg::ipsm_periph_type periph_in;
  logic                      cfg_mismatch_rst;
  logic [1:0]                chk_kind = 2'h0; // 1 compares hrdata, 2 periph_in.
  logic [5:0]                exp_sel [15];    // Model of the select fields.
  logic [7:0]                ofs [8] = '{`IPSM_OFS_SEL0, `IPSM_OFS_SEL1, `IPSM_OFS_SEL2,
    `IPSM_OFS_SEL3, `IPSM_OFS_SEL5, `IPSM_OFS_SEL6, `IPSM_OFS_SEL7, `IPSM_OFS_SEL8};
  ipsm_note_type             notes [$];       // Expected results, oldest first.
  int                        n_mismatch = 0;
  int                        n_compared = 0;

  ipsm_input_pin_select_mux #(.NUM_PINS(NP)) ipsm_input_pin_select_mux_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .remap_lock(remap_lock),
    .remap_pin(remap_pin), .periph_in(periph_in), .cfg_mismatch_rst(cfg_mismatch_rst));

  // The clock toggles every 4 ns, a period of 8 ns.
  always #4 hclk = ~hclk;

  // Compares one value and counts it.
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // One single AHB transfer; the data phase holds until hready is seen high.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    chk_kind <= wr ? 2'h0 : 2'h1;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    chk_kind <= 2'h0;
  endtask

  // Reads one register against a noted value.
  task automatic rd(input string name, input logic [7:0] a, input logic [31:0] e);
    notes.push_back('{name, e});
    bus(1'b0, a, 32'h0);
  endtask

  // Writes the select register of slot k and updates the model while unlocked.
  task automatic wr_sel(input int k, input logic [31:0] d);
    bus(1'b1, ofs[k], d);
    if (remap_lock === 1'b0) begin
      exp_sel[2*k] = d[5:0];
      if (k < 7) exp_sel[2*k+1] = d[13:8];
    end
  endtask

  // Expected register word: two fields, or only the low one in the last slot.
  function automatic logic [31:0] exp_reg(input int k);
    return k < 7 ? {18'h0, exp_sel[2*k+1], 2'h0, exp_sel[2*k]} : {26'h0, exp_sel[14]};
  endfunction

  // Drives pin levels and checks periph_in once the three stages have passed.
  task automatic pins(input logic [NP-1:0] p);
    logic [14:0] r;
    r = '0;
    for (int f = 0; f < 15; f++) begin
      if (exp_sel[f] < NP) r[f] = p[exp_sel[f]];
    end
    @(posedge hclk);
    remap_pin <= p;
    repeat (3) @(posedge hclk);
    notes.push_back('{"periph_in", {17'h0, r}});
    chk_kind <= 2'h2;
    @(posedge hclk);
    chk_kind <= 2'h0;
  endtask

  // Holds reset for six cycles and returns the model to all ones.
  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (exp_sel[f]) exp_sel[f] = `IPSM_SEL_RST;
  endtask

  // Monitor: takes the oldest note whenever a result is presented.
  always @(posedge hclk) begin
    ipsm_note_type nt;
    if (chk_kind != 2'h0 && notes.size() > 0) begin
      nt = notes.pop_front();
      check(nt.name, nt.exp, chk_kind == 2'h1 ? hrdata : {17'h0, periph_in});
      if (chk_kind == 2'h1) check("hresp", 32'h0, {31'h0, hresp});
      if (chk_kind == 2'h1) check("hreadyout", 32'h1, {31'h0, hreadyout});
    end
  end

  // Main sequence.
  initial begin
    logic [63:0] pv;
    logic [31:0] d;
    void'($urandom(32'hD4B81082));
    do_reset();
    for (int k = 0; k < 8; k++) rd("reset value", ofs[k], exp_reg(k));
    pins('1);
    $display("test reset done");
    for (int i = 0; i < 24; i++) begin
      d = i < 8 ? $urandom & 32'h1F1F : $urandom;
      pv = {$urandom, $urandom};
      wr_sel(i % 8, d);
      rd("select readback", ofs[i % 8], exp_reg(i % 8));
      pins(pv[NP-1:0]);
    end
    $display("test routing done");
    @(posedge hclk);
    remap_lock <= 1'b1;
    for (int k = 0; k < 8; k++) wr_sel(k, ~exp_reg(k));
    rd("status", `IPSM_OFS_STAT, 32'h1);
    for (int k = 0; k < 8; k++) rd("locked value", ofs[k], exp_reg(k));
    @(posedge hclk);
    remap_lock <= 1'b0;
    wr_sel(7, 32'h0000_0005);
    rd("unlocked write", ofs[7], 32'h5);
    bus(1'b1, 8'h10, $urandom);
    rd("unmapped", 8'h10, 32'h0);
    $display("test lock done");
    check("mismatch reset", 32'h0, {31'h0, cfg_mismatch_rst});
    do_reset();
    rd("second reset", ofs[0], 32'h3F3F);
    rd("second reset", ofs[7], 32'h3F);
    $display("test second reset done");
    results();
  end

  // Watchdog: the sequence needs a few hundred cycles at most.
  initial begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    results();
  end
endmodule
